// ===== ebh_pkg.sv
// Constants for the external bus release handshake.
// Assumes one 100 MHz timing clock and a synchronous active-high reset.
package ebh_pkg;
	localparam int          EBH_ADDR_W      = 19;
	localparam int          EBH_DATA_W      = 16;
	localparam int          EBH_ACC_CYCLES  = 3;
	localparam logic [1:0]  EBH_ZONE_A      = 2'h0;
	localparam logic [1:0]  EBH_ZONE_B      = 2'h1;
	localparam logic        EBH_HOLD_MODE_RST = 1'b0;
	localparam int          EBH_CLK_NS      = 10;
	localparam int          EBH_HIZ_FULL_NS = 4 * EBH_CLK_NS;
	localparam int          EBH_HIZ_FULL_CYC = EBH_HIZ_FULL_NS / EBH_CLK_NS;
	localparam int          EBH_GNT_FULL_NS = 5 * EBH_CLK_NS;
	localparam int          EBH_GNT_FULL_CYC = EBH_GNT_FULL_NS / EBH_CLK_NS;
	localparam int          EBH_REL_FULL_NS = 3 * EBH_CLK_NS;
	localparam int          EBH_REL_FULL_CYC = EBH_REL_FULL_NS / EBH_CLK_NS;
	typedef enum logic [2:0] {
		EBH_IDLE,
		EBH_ACCESS,
		EBH_HIZ,
		EBH_GRANT,
		EBH_ABORT
	} ebh_state_t;
endpackage

// ===== ebh_clk_phase.sv
// Output clock phase generator for the external bus.
// Assumes the timing clock is clock_in; half rate divides it by two.
`timescale 1ns/1ns
module ebh_clk_phase
	import ebh_pkg::*;
(
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic reset_in,
	// Mode
	input  wire logic half_rate_in,
	// Phase
	output logic      clk_half_out,
	output logic      edge_ok_out
);
	// At half rate the next edge is an output clock rise when the divider is low
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			clk_half_out <= 1'b0;
		end else if (half_rate_in) begin
			clk_half_out <= ~clk_half_out;
		end else begin
			clk_half_out <= 1'b0;
		end
	end
	assign edge_ok_out = !half_rate_in || !clk_half_out;
endmodule

// ===== ebh_hold.sv
// External bus interface with bus release handshake to an outside master.
// Assumes pins sampled synchronously to clock_in; pads resolve the enables.
`timescale 1ns/1ns
module ebh_hold
	import ebh_pkg::*;
#(
	parameter int ACC_CYCLES = EBH_ACC_CYCLES
) (
	// Clock and reset
	input  wire logic                  clock_in,
	input  wire logic                  reset_in,
	// Mode control
	input  wire logic                  half_rate_in,
	input  wire logic                  hold_mode_wr_in,
	input  wire logic                  hold_mode_data_in,
	output logic                       hold_mode_out,
	// Internal access port
	input  wire logic                  acc_req_in,
	input  wire logic                  acc_write_in,
	input  wire logic [1:0]            acc_zone_in,
	input  wire logic [EBH_ADDR_W-1:0] acc_addr_in,
	input  wire logic [EBH_DATA_W-1:0] acc_wdata_in,
	output logic                       acc_ready_out,
	output logic                       acc_done_out,
	output logic [EBH_DATA_W-1:0]      acc_rdata_out,
	// Release handshake
	input  wire logic                  bus_release_request_n_in,
	output logic                       bus_release_grant_n_out,
	// External bus
	output logic                       interface_clock_out,
	output logic [EBH_ADDR_W-1:0]      ext_address_bus_out,
	output logic [EBH_DATA_W-1:0]      ext_data_bus_out,
	input  wire logic [EBH_DATA_W-1:0] ext_data_bus_in,
	output logic                       ext_data_bus_oe_out,
	output logic                       ext_write_strobe_n_out,
	output logic                       ext_read_strobe_n_out,
	output logic                       ext_direction_out,
	output logic                       zone_select_a_n_out,
	output logic                       zone_select_b_n_out,
	output logic                       zone_select_c_n_out,
	output logic                       ext_ctrl_oe_out
);
	localparam int LIM_HIZ = EBH_HIZ_FULL_CYC - 1;
	localparam int LIM_GNT = EBH_GNT_FULL_CYC - 1;
	localparam int LIM_REL = EBH_REL_FULL_CYC - 1;
	localparam int LIM_ACC = ACC_CYCLES + 3;

	ebh_state_t      state_q;
	logic            req_q;
	logic            hold_mode_q;
	logic            hold_rise;
	logic            edge_ok;
	logic            write_q;
	logic [7:0]      cnt_q;
	logic            accept;

	ebh_clk_phase u_phase (
		.clock_in     (clock_in),
		.reset_in     (reset_in),
		.half_rate_in (half_rate_in),
		.clk_half_out (interface_clock_out),
		.edge_ok_out  (edge_ok)
	);

	// A request caught during reset is honoured at once
	always_ff @(posedge clock_in) begin
		req_q <= bus_release_request_n_in;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			hold_mode_q <= EBH_HOLD_MODE_RST;
		end else if (hold_mode_wr_in) begin
			hold_mode_q <= hold_mode_data_in;
		end
	end
	assign hold_mode_out = hold_mode_q;
	assign hold_rise     = hold_mode_wr_in && hold_mode_data_in && !hold_mode_q;

	// At half rate, accesses start only on an output clock rise; at full rate on any edge
	assign accept = acc_req_in && acc_ready_out && edge_ok;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_q                 <= bus_release_request_n_in ? EBH_IDLE : EBH_GRANT;
			bus_release_grant_n_out <= bus_release_request_n_in;
			ext_ctrl_oe_out         <= bus_release_request_n_in;
		end else begin
			case (state_q)
				EBH_IDLE: begin
					// A pending access wins over a fresh request
					if (accept) begin
						state_q <= EBH_ACCESS;
					end else if (!req_q && edge_ok) begin
						ext_ctrl_oe_out <= 1'b0;
						state_q         <= EBH_HIZ;
					end
				end
				EBH_ACCESS: begin
					if (cnt_q == 8'(ACC_CYCLES - 1)) begin
						state_q <= EBH_IDLE;
					end
				end
				EBH_HIZ: begin
					if (req_q && edge_ok) begin
						ext_ctrl_oe_out <= 1'b1;
						state_q         <= EBH_IDLE;
					end else if (edge_ok) begin
						bus_release_grant_n_out <= 1'b0;
						state_q                 <= EBH_GRANT;
					end
				end
				EBH_GRANT: begin
					if (hold_rise) begin
						// Forced off at the next edge, not aligned to the output clock
						bus_release_grant_n_out <= 1'b1;
						ext_ctrl_oe_out         <= 1'b1;
						state_q                 <= EBH_ABORT;
					end else if (req_q && edge_ok) begin
						bus_release_grant_n_out <= 1'b1;
						ext_ctrl_oe_out         <= 1'b1;
						state_q                 <= EBH_IDLE;
					end
				end
				default: begin
					// No new grant until the master withdraws its request
					if (req_q) begin
						state_q <= EBH_IDLE;
					end
				end
			endcase
		end
	end

	// Stall port: no access is taken while the bus is released
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			acc_ready_out <= 1'b0;
		end else begin
			acc_ready_out <= state_q == EBH_IDLE && req_q && !accept;
		end
	end

	// Access sequencing: lead, active, then strobes and selects released on the same edge
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cnt_q                  <= 8'h00;
			write_q                <= 1'b0;
			acc_done_out           <= 1'b0;
			acc_rdata_out          <= 16'h0000;
			ext_address_bus_out    <= 19'h0_0000;
			ext_data_bus_out       <= 16'h0000;
			ext_data_bus_oe_out    <= 1'b0;
			ext_write_strobe_n_out <= 1'b1;
			ext_read_strobe_n_out  <= 1'b1;
			ext_direction_out      <= 1'b1;
			zone_select_a_n_out    <= 1'b1;
			zone_select_b_n_out    <= 1'b1;
			zone_select_c_n_out    <= 1'b1;
		end else begin
			acc_done_out <= 1'b0;
			if (accept) begin
				cnt_q               <= 8'h00;
				write_q             <= acc_write_in;
				ext_address_bus_out <= acc_addr_in;
				ext_data_bus_out    <= acc_wdata_in;
				ext_data_bus_oe_out <= acc_write_in;
				ext_direction_out   <= !acc_write_in;
				zone_select_a_n_out <= acc_zone_in != EBH_ZONE_A;
				zone_select_b_n_out <= acc_zone_in != EBH_ZONE_B;
				zone_select_c_n_out <= acc_zone_in == EBH_ZONE_A || acc_zone_in == EBH_ZONE_B;
			end else if (state_q == EBH_ACCESS) begin
				cnt_q <= cnt_q + 8'h01;
				if (cnt_q == 8'h00) begin
					ext_write_strobe_n_out <= !write_q;
					ext_read_strobe_n_out  <= write_q;
				end
				if (cnt_q == 8'(ACC_CYCLES - 1)) begin
					// Address holds its last value between accesses
					acc_done_out           <= 1'b1;
					acc_rdata_out          <= ext_data_bus_in;
					ext_write_strobe_n_out <= 1'b1;
					ext_read_strobe_n_out  <= 1'b1;
					ext_direction_out      <= 1'b1;
					ext_data_bus_oe_out    <= 1'b0;
					zone_select_a_n_out    <= 1'b1;
					zone_select_b_n_out    <= 1'b1;
					zone_select_c_n_out    <= 1'b1;
				end
			end
		end
	end

	sequence s_req_fall;
		$fell(req_q) && state_q == EBH_IDLE && !half_rate_in;
	endsequence
	sequence s_req_rise;
		$rose(req_q) && state_q == EBH_GRANT && !half_rate_in && !hold_mode_wr_in;
	endsequence

	a_sample_req: assert property (@(posedge clock_in) disable iff (reset_in)
		req_q == $past(bus_release_request_n_in)) else $error("request not registered");
	a_hiz_in_time: assert property (@(posedge clock_in) disable iff (reset_in)
		s_req_fall |-> ##[1:LIM_HIZ] (!ext_ctrl_oe_out || req_q)) else $error("bus late to float");
	a_grant_in_time: assert property (@(posedge clock_in) disable iff (reset_in)
		s_req_fall ##1 (!req_q)[*3] |-> ##[0:LIM_GNT] !bus_release_grant_n_out)
		else $error("grant late");
	a_grant_after_hiz: assert property (@(posedge clock_in) disable iff (reset_in)
		$fell(bus_release_grant_n_out) |-> !ext_ctrl_oe_out && !$past(ext_ctrl_oe_out)
		&& !ext_data_bus_oe_out) else $error("grant before bus floated");
	a_release_in_time: assert property (@(posedge clock_in) disable iff (reset_in)
		s_req_rise |-> ##[0:LIM_REL] bus_release_grant_n_out) else $error("grant release late");
	a_bus_back: assert property (@(posedge clock_in) disable iff (reset_in)
		$rose(bus_release_grant_n_out) |-> ext_ctrl_oe_out) else $error("bus not driven");
	a_half_align: assert property (@(posedge clock_in) disable iff (reset_in)
		half_rate_in && $past(half_rate_in) && $fell(ext_ctrl_oe_out) |-> $past(edge_ok))
		else $error("transition off output clock rise");
	a_access_ends: assert property (@(posedge clock_in) disable iff (reset_in)
		accept |-> ##[1:LIM_ACC] acc_done_out) else $error("access never completed");
	a_hold_abort: assert property (@(posedge clock_in) disable iff (reset_in)
		hold_rise && state_q == EBH_GRANT |=> bus_release_grant_n_out && ext_ctrl_oe_out)
		else $error("hold mode did not force release");
	// Skips the first two reset edges: the request pin may not be driven before them
	a_reset_mode: assert property (@(posedge clock_in)
		$past(reset_in, 2) && $past(reset_in) && reset_in |-> !hold_mode_q
		&& bus_release_grant_n_out == $past(bus_release_request_n_in))
		else $error("reset state wrong");
	a_stall_grant: assert property (@(posedge clock_in) disable iff (reset_in)
		!bus_release_grant_n_out |-> !acc_ready_out && state_q != EBH_ACCESS)
		else $error("access during grant");
	a_float_all: assert property (@(posedge clock_in) disable iff (reset_in)
		state_q == EBH_ACCESS |-> ext_ctrl_oe_out) else $error("access with bus floated");
endmodule

// ===== ebh_master.sv
// Model of the outside master that borrows the external bus.
// Assumes the bench raises go_in while it wants the bus.
`timescale 1ns/1ns
module ebh_master (
	// Clock and reset
	input  wire logic clock_in,
	input  wire logic reset_in,
	// Control and grant
	input  wire logic go_in,
	input  wire logic grant_n_in,
	// Bus side
	output logic      req_n_out,
	output logic      drive_out
);
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			req_n_out <= !go_in;
			drive_out <= 1'b0;
		end else begin
			drive_out <= go_in && !grant_n_in;
			// Raise the request only once off the bus, so the two never fight
			if (go_in)
				req_n_out <= 1'b0;
			else if (!drive_out)
				req_n_out <= 1'b1;
		end
	end
endmodule

// ===== ebh_hold_tb.sv
// Self-checking bench for the bus release handshake.
// Assumes the partner model ebh_master owns the request pin.
`timescale 1ns/1ns
module ebh_hold_tb;
	import ebh_pkg::*;
	logic                  clock_in = 0, reset_in = 1, half = 0, wr = 0, wd = 0, go = 0;
	logic                  req = 0, w = 0, rdy, done, hm, gnt_n, req_n, drv, wst_n, rst_n;
	logic                  doe, dir, za_n, zb_n, zc_n, coe, xclk;
	logic [1:0]            zone = 0;
	logic [EBH_ADDR_W-1:0] addr = 0, xa;
	logic [EBH_DATA_W-1:0] wdat = 0, mem = 0, rdat, xdo;
	int                    error_cnt = 0, n_compared = 0, i;
	always #5 clock_in = ~clock_in;
	ebh_hold ebh_hold_inst (.clock_in, .reset_in, .half_rate_in(half), .hold_mode_wr_in(wr),
		.hold_mode_data_in(wd), .hold_mode_out(hm), .acc_req_in(req), .acc_write_in(w),
		.acc_zone_in(zone), .acc_addr_in(addr), .acc_wdata_in(wdat), .acc_ready_out(rdy),
		.acc_done_out(done), .acc_rdata_out(rdat), .bus_release_request_n_in(req_n),
		.bus_release_grant_n_out(gnt_n), .interface_clock_out(xclk), .ext_address_bus_out(xa),
		.ext_data_bus_out(xdo), .ext_data_bus_in(doe ? xdo : mem), .ext_data_bus_oe_out(doe),
		.ext_write_strobe_n_out(wst_n), .ext_read_strobe_n_out(rst_n),
		.ext_direction_out(dir), .zone_select_a_n_out(za_n), .zone_select_b_n_out(zb_n),
		.zone_select_c_n_out(zc_n), .ext_ctrl_oe_out(coe));
	ebh_master ebh_master_inst (.clock_in, .reset_in, .go_in(go), .grant_n_in(gnt_n),
		.req_n_out(req_n), .drive_out(drv));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tick;
		@(posedge clock_in);
		#1;
	endtask
	// Active-low selects as {c, b, a}; codes 2 and 3 share zone c
	function automatic logic [2:0] zexp(input logic [1:0] z);
		return z == 0 ? 3'b110 : z == 1 ? 3'b101 : 3'b011;
	endfunction
	task automatic acc(input logic wi, input int n_exp);
		int n;
		tick;
		w = wi; zone = $urandom; addr = $urandom; wdat = $urandom; mem = $urandom; req = 1;
		n = 0;
		do begin
			tick;
			n++;
			chk(coe, 1);
			if (!(wi ? wst_n : rst_n))
				chk({zc_n, zb_n, za_n, dir, xa}, {zexp(zone), !wi, addr});
			if (!wst_n && wi)
				chk({doe, xdo}, {1'b1, wdat});
		end while (!done && n < 40);
		req = 0;
		chk(done, 1);
		if (n_exp > 0)
			chk(n, n_exp);
		if (!wi)
			chk(rdat, mem);
	endtask
	// Latency limits are counted in edges from the pin change
	task automatic holdt(input int hz, input int ga, input int rg, input int bv);
		int th, tg;
		go = 1;
		for (i = 0; i < 5 && req_n; i++) tick;
		th = 0; tg = 0;
		for (i = 1; i <= 10; i++) begin
			tick;
			if (!coe && th == 0) begin
				th = i;
				chk(xclk, half);
			end
			if (!gnt_n && tg == 0) begin
				tg = i;
				chk(xclk, half);
			end
		end
		chk(th > 0 && th <= hz, 1);
		chk(tg > 0 && tg <= ga, 1);
		chk({doe, rdy, drv}, 3'b001);
		go = 0;
		for (i = 0; i < 5 && !req_n; i++) tick;
		th = 0; tg = 0;
		for (i = 1; i <= 10; i++) begin
			tick;
			if (coe && th == 0) begin
				th = i;
				chk(xclk, half);
			end
			if (gnt_n && tg == 0) begin
				tg = i;
				chk(xclk, half);
			end
		end
		chk(tg > 0 && tg <= rg, 1);
		chk(th > 0 && th <= bv, 1);
	endtask
	task automatic rst(input logic h, input logic g);
		reset_in = 1; half = h; go = g;
		repeat (16) tick;
		chk({hm, gnt_n, coe, xclk}, {1'b0, !g, !g, 1'b0});
		reset_in = 0;
	endtask
	initial begin
		void'($urandom(27));
		rst(0, 0);
		acc(1, EBH_ACC_CYCLES + 1);
		acc(0, EBH_ACC_CYCLES + 1);
		repeat (6) acc($urandom, EBH_ACC_CYCLES + 1);
		holdt(4, 5, 3, 4);
		// Request arrives while an access is in flight
		fork
			acc(0, 0);
			begin tick; tick; tick; go = 1; end
		join
		holdt(10, 10, 3, 4);
		go = 1;
		for (i = 0; i < 12 && gnt_n; i++) tick;
		chk(gnt_n, 0);
		wr = 1; wd = 1;
		tick;
		wr = 0;
		tick;
		chk({gnt_n, coe, hm}, 3'b111);
		rst(0, 1);
		go = 0;
		repeat (8) tick;
		chk({gnt_n, coe}, 2'b11);
		rst(1, 0);
		repeat (4) acc($urandom, 0);
		holdt(6, 8, 4, 6);
		acc(1, 0);
		conclude;
	end
	initial begin
		#20000;
		error_cnt++;
		conclude;
	end
endmodule
